//--- hdl/smi_request_aggregator.sv
// Collects management-interrupt request sources and drives the active-low interrupt line.
`timescale 1ns/1ps
module smi_request_aggregator
  import smi_agg_pkg::*;
#(
  parameter int UNBLOCK_CNT = UNBLOCK_CYCLES
) (
  // Clock and reset.
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // Register port.
  input  wire logic [7:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [15:0] o_rdata,
  // Request sources from same-clock logic, one-cycle pulses or levels.
  input  wire logic [15:0] i_src_req,
  // Interrupt lines 0 to 15 from pins.
  input  wire logic [15:0] i_irq_line,
  // Outputs to the processor and the throttling timer.
  output logic             o_system_mgmt_interrupt_out_n,
  output logic             o_throttle_reload,
  output logic             o_blocked,
  output logic             o_irq
);

  // ---------------------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------------------
  logic [15:0] status_reg, status_next;
  logic [15:0] select_reg, select_next;
  logic [15:0] line_sel_reg, line_sel_next;
  logic [15:0] reload_sel_reg, reload_sel_next;
  logic [1:0]  evt_reg, evt_next;
  logic [1:0]  emask_reg, emask_next;
  logic        smi_reg, smi_next;
  logic        block_reg, block_next;
  logic        reload_next;
  logic        irq_next;
  logic [15:0] rdata_next;
  logic [15:0] line_sync;
  logic [15:0] line_prev_reg;
  logic [15:0] line_rise;
  logic [15:0] set_bits;
  logic [15:0] clr_bits;
  logic [15:0] sel_eff;
  logic        wr_status;
  logic        wr_trigger;
  logic        soft_trig;
  logic        unblock_start;
  logic        unblock_expire;
  logic        pending;

  // ---------------------------------------------------------------------------
  // Input conditioning
  // ---------------------------------------------------------------------------

  // Interrupt lines come from pins and are synchronised before use.
  sync2 #(
    .WIDTH (16)
  ) u_line_sync (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_async (i_irq_line),
    .o_sync  (line_sync)
  );

  // Edge history of the synchronised lines.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      line_prev_reg <= RST_REG16;
    end else begin
      line_prev_reg <= line_sync;
    end
  end

  assign line_rise = line_sync & ~line_prev_reg;

  // ---------------------------------------------------------------------------
  // Write decode
  // ---------------------------------------------------------------------------
  assign wr_status     = i_wr && (i_addr == OFS_REQ_STATUS);
  assign wr_trigger    = i_wr && (i_addr == OFS_TRIGGER);
  // R12: software trigger strobe
  assign soft_trig     = wr_trigger && i_wdata[TRIG_SOFT_BIT];
  // R11: unblocking timer start
  assign unblock_start = wr_trigger && i_wdata[TRIG_UNBLOCK_BIT];

  unblock_timer #(
    .CYCLES (UNBLOCK_CNT)
  ) u_unblock (
    .i_clk    (i_clk),
    .i_rst_n  (i_rst_n),
    .i_start  (unblock_start),
    .o_expire (unblock_expire),
    .o_busy   ()
  );

  // ---------------------------------------------------------------------------
  // Request latching and interrupt line
  // ---------------------------------------------------------------------------

  // Computes request set and clear terms; a set in the clear cycle wins.
  always_comb begin
    sel_eff  = select_reg | SEL_FORCED;
    // R4, R5, R6, R7, R8: source inputs mapped to their status bits
    set_bits = i_src_req & HW_SRC_MASK & sel_eff;
    // R9: enabled interrupt line edges form the IRQ request
    set_bits[BIT_IRQ] = (|(line_rise & line_sel_reg)) & select_reg[BIT_IRQ];
    // R12: software request bit set by the trigger
    set_bits[BIT_SOFT] = soft_trig;
    // R2: ones written clear their bits
    clr_bits = wr_status ? i_wdata : RST_REG16;
    // R1: latched requests stay until cleared
    status_next = (status_reg & ~clr_bits) | set_bits;
  end

  // Drives the interrupt line and the blocking mask.
  always_comb begin
    // R13: selected pending request asserts the line
    pending = |(status_reg & sel_eff);
    // R11: while blocked the line may only stay asserted, never re-assert
    if (block_reg) begin
      smi_next = smi_reg && pending;
    end else begin
      smi_next = pending;
    end
    block_next = block_reg;
    if (unblock_expire) begin
      block_next = 1'b0;
    end
    // R11: blocking mask set on every assertion
    if (smi_next && !smi_reg) begin
      block_next = 1'b1;
    end
  end

  // R10: enabled line edges reload the throttling timer
  assign reload_next = |(line_rise & reload_sel_reg);

  // ---------------------------------------------------------------------------
  // Configuration, event interrupt and read path
  // ---------------------------------------------------------------------------

  // Next values of the software-written registers and the event flags.
  always_comb begin
    select_next     = select_reg;
    line_sel_next   = line_sel_reg;
    reload_sel_next = reload_sel_reg;
    emask_next      = emask_reg;
    evt_next        = evt_reg;
    if (i_wr) begin
      case (i_addr)
        // R3: reserved top bit of the selection never stores
        OFS_SRC_SELECT:  select_next     = i_wdata & SEL_WRITABLE;
        // R9: per-line enables of the IRQ request
        OFS_LINE_SELECT: line_sel_next   = i_wdata;
        // R10: per-line reload enables
        OFS_RELOAD_SEL:  reload_sel_next = i_wdata;
        OFS_EVT_STATUS:  evt_next        = evt_reg & ~i_wdata[1:0];
        OFS_EVT_MASK:    emask_next      = i_wdata[1:0];
        default:         ;
      endcase
    end
    if (smi_next && !smi_reg) begin
      evt_next[EVT_ASSERT_BIT] = 1'b1;
    end
    if (unblock_expire) begin
      evt_next[EVT_UNBLOCK_BIT] = 1'b1;
    end
    irq_next = |(evt_next & emask_next);
  end

  // Read data for the cycle after the strobe; zero otherwise.
  always_comb begin
    rdata_next = RST_REG16;
    if (i_rd) begin
      case (i_addr)
        OFS_REQ_STATUS:  rdata_next = status_reg;
        OFS_SRC_SELECT:  rdata_next = select_reg;
        OFS_LINE_SELECT: rdata_next = line_sel_reg;
        OFS_RELOAD_SEL:  rdata_next = reload_sel_reg;
        OFS_EVT_STATUS:  rdata_next = {14'h0000, evt_reg};
        OFS_EVT_MASK:    rdata_next = {14'h0000, emask_reg};
        default:         rdata_next = RST_REG16;
      endcase
    end
  end

  // R14: all registers clear on reset
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      status_reg                    <= RST_REG16;
      select_reg                    <= RST_REG16;
      line_sel_reg                  <= RST_REG16;
      reload_sel_reg                <= RST_REG16;
      evt_reg                       <= RST_EVT;
      emask_reg                     <= RST_EVT;
      smi_reg                       <= 1'b0;
      block_reg                     <= 1'b0;
      o_rdata                       <= RST_REG16;
      o_system_mgmt_interrupt_out_n <= 1'b1;
      o_throttle_reload             <= 1'b0;
      o_blocked                     <= 1'b0;
      o_irq                         <= 1'b0;
    end else begin
      status_reg                    <= status_next;
      select_reg                    <= select_next;
      line_sel_reg                  <= line_sel_next;
      reload_sel_reg                <= reload_sel_next;
      evt_reg                       <= evt_next;
      emask_reg                     <= emask_next;
      smi_reg                       <= smi_next;
      block_reg                     <= block_next;
      o_rdata                       <= rdata_next;
      o_system_mgmt_interrupt_out_n <= !smi_next;
      o_throttle_reload             <= reload_next;
      o_blocked                     <= block_next;
      o_irq                         <= irq_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------

  // R2: write-one clear
  a_w1c_clears: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R2
    (wr_status && i_wdata[BIT_DMA] && !i_src_req[BIT_DMA]) |=> !status_reg[BIT_DMA])
    else $error("Status bit not cleared by a one.");

  // R2: write-zero keeps bit
  a_w0_keeps: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R2
    (wr_status && !i_wdata[BIT_DMA] && status_reg[BIT_DMA]) |=> status_reg[BIT_DMA])
    else $error("Status bit lost on a zero write.");

  // R13: gated latching
  a_sel_gates_latch: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R13
    (!status_reg[BIT_DISK] && !select_reg[BIT_DISK]) |=> !status_reg[BIT_DISK])
    else $error("Unselected source latched.");

  // R12: software trigger
  a_soft_sets_bit: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R12
    soft_trig |=> status_reg[BIT_SOFT] ##1 (block_reg || !o_system_mgmt_interrupt_out_n))
    else $error("Software trigger did not raise the request.");

  // R11: mask on assertion
  a_block_on_assert: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R11
    $fell(o_system_mgmt_interrupt_out_n) |-> o_blocked)
    else $error("Assertion without blocking mask.");

  // R11: no re-assertion while blocked
  a_no_nesting: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R11
    ($past(o_blocked) && $past(o_system_mgmt_interrupt_out_n)) |-> o_system_mgmt_interrupt_out_n)
    else $error("Nested management interrupt.");

  // R11: timer releases mask
  a_unblock_release: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R11
    (unblock_start && !soft_trig && !pending) ##1 !unblock_start [*3]
      |-> ##[1:250] !o_blocked)
    else $error("Blocking mask not released by the timer.");

  // R13: line follows pending
  a_line_needs_req: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R13
    !o_system_mgmt_interrupt_out_n |-> $past(pending))
    else $error("Line asserted with no selected request.");

  // R3: reserved select bit
  a_reserved_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R3
    !select_reg[15])
    else $error("Reserved selection bit stored.");

  // R10: reload pulse
  a_reload_pulse: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R10
    (|(line_rise & reload_sel_reg)) |=> o_throttle_reload)
    else $error("Throttle reload missed.");

  // R10: disabled lines never reload
  a_reload_gated: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R10
    !(|(line_rise & reload_sel_reg)) |=> !o_throttle_reload)
    else $error("Throttle reload without an enabled line edge.");

  // R1: status read returns latched requests
  a_status_read: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R1
    (i_rd && (i_addr == OFS_REQ_STATUS)) |=> (o_rdata == $past(status_reg)))
    else $error("Status read returned the wrong requests.");

  // R1: read data only after a read
  a_rdata_idle: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R1
    !i_rd |=> (o_rdata == RST_REG16))
    else $error("Read data present without a read.");

  // R9: enabled line edge latches
  a_line_latch: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R9
    ((|(line_rise & line_sel_reg)) && select_reg[BIT_IRQ]) |=> status_reg[BIT_IRQ])
    else $error("Enabled interrupt line edge not latched.");

  // R12: zero trigger has no effect
  a_zero_trigger: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R12
    (wr_trigger && !i_wdata[TRIG_SOFT_BIT] && !status_reg[BIT_SOFT]) |=> !status_reg[BIT_SOFT])
    else $error("Zero trigger write raised the software request.");

  // R14: reset returns to idle
  a_reset_idle: assert property (@(posedge i_clk) // R14
    !i_rst_n |=> (o_system_mgmt_interrupt_out_n && !o_blocked && (status_reg == RST_REG16)))
    else $error("Reset did not return the block to idle.");

endmodule : smi_request_aggregator

//--- common/smi_agg_pkg.sv
// Constants, register map and field layout of the management-interrupt request aggregator.
// How it works
// R1: Sixteen status bits each latch that their source requested the current interrupt.
// R2: Writing one to a status bit clears it; writing zero leaves it alone.
// R3: Source-selection bits choose monitored events; its top bit is reserved.
// R4: Bit 15 deturbo switch, bit 5 break switch, bit 4 software request.
// R5: Bit 14 records video memory and video port access requests.
// R6: Bits 12, 11, 10 carry fast, generic and slow timer expiry.
// R7: Bits 9 to 6 carry serial, parallel, disk and keyboard/mouse requests.
// R8: Bits 3, 2 carry I/O traps 1, 0; bit 1 bus master; bit 0 DMA.
// R9: Bit 13 is the IRQ request, fed by lines enabled in the line-select register.
// R10: A per-line register chooses which interrupt lines reload the throttling timer.
// R11: Asserting the interrupt sets a blocking mask, cleared by the unblocking timer.
// R12: Writing one to the software trigger asserts the interrupt as the software request.
// R13: Output asserts while a selected status bit is set and blocking is clear.
// R14: All six registers reset to zero.
package smi_agg_pkg;

  // ---------------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OFS_TRIGGER     = 8'h9E;
  localparam logic [7:0] OFS_REQ_STATUS  = 8'hA0;
  localparam logic [7:0] OFS_SRC_SELECT  = 8'hA2;
  localparam logic [7:0] OFS_LINE_SELECT = 8'hA4;
  localparam logic [7:0] OFS_RELOAD_SEL  = 8'hA6;
  localparam logic [7:0] OFS_EVT_STATUS  = 8'hAC;
  localparam logic [7:0] OFS_EVT_MASK    = 8'hAE;

  // ---------------------------------------------------------------------------
  // Status bit positions
  // ---------------------------------------------------------------------------
  localparam int BIT_DETURBO  = 15;
  localparam int BIT_VIDEO    = 14;
  localparam int BIT_IRQ      = 13;
  localparam int BIT_FAST_TMR = 12;
  localparam int BIT_GEN_TMR  = 11;
  localparam int BIT_SLOW_TMR = 10;
  localparam int BIT_SERIAL   = 9;
  localparam int BIT_PARALLEL = 8;
  localparam int BIT_DISK     = 7;
  localparam int BIT_KBD      = 6;
  localparam int BIT_BREAK    = 5;
  localparam int BIT_SOFT     = 4;
  localparam int BIT_TRAP1    = 3;
  localparam int BIT_TRAP0    = 2;
  localparam int BIT_BUS_MST  = 1;
  localparam int BIT_DMA      = 0;

  // Trigger register bits and event status bits.
  localparam int TRIG_SOFT_BIT    = 0;
  localparam int TRIG_UNBLOCK_BIT = 1;
  localparam int EVT_ASSERT_BIT   = 0;
  localparam int EVT_UNBLOCK_BIT  = 1;

  // Select bit 15 is reserved; the deturbo request is always monitored.
  localparam logic [15:0] SEL_WRITABLE = 16'h7FFF;
  localparam logic [15:0] SEL_FORCED   = 16'h8010;
  // Bits fed by the source inputs, not produced inside the block.
  localparam logic [15:0] HW_SRC_MASK  = 16'hDFEF;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [15:0] RST_REG16 = 16'h0000;
  localparam logic [1:0]  RST_EVT   = 2'h0;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 5;
  localparam int UNBLOCK_TIME_NS = 1000;
  localparam int UNBLOCK_CYCLES  = (UNBLOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [0:0] {TMR_IDLE, TMR_COUNT} unblock_state_t;

endpackage : smi_agg_pkg

//--- hdl/sync2.sv
// Two-flip-flop synchroniser for a bus of independent pin levels.
`timescale 1ns/1ps
module sync2 #(
  parameter int WIDTH = 16
) (
  // Clock and reset.
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  // Asynchronous levels in, synchronous levels out.
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_reg;

  // The first stage feeds only the second stage.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_reg <= '0;
      o_sync   <= '0;
    end else begin
      meta_reg <= i_async;
      o_sync   <= meta_reg;
    end
  end

endmodule : sync2

//--- hdl/unblock_timer.sv
// One-shot countdown that ends the interrupt blocking window.
`timescale 1ns/1ps
module unblock_timer
  import smi_agg_pkg::*;
#(
  parameter int CYCLES = UNBLOCK_CYCLES
) (
  // Clock and reset.
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // Start strobe, expiry pulse and busy level.
  input  wire logic i_start,
  output logic      o_expire,
  output logic      o_busy
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(CYCLES);
  localparam logic [CW-1:0] ONE  = CW'(1);

  unblock_state_t state_reg, state_next;
  logic [CW-1:0]  cnt_reg, cnt_next;
  logic           expire_next;

  // A start while counting restarts the full interval.
  always_comb begin
    state_next  = state_reg;
    cnt_next    = cnt_reg;
    expire_next = 1'b0;
    case (state_reg)
      TMR_IDLE: begin
        if (i_start) begin
          state_next = TMR_COUNT;
          cnt_next   = LOAD;
        end
      end
      TMR_COUNT: begin
        if (i_start) begin
          cnt_next = LOAD;
        end else if (cnt_reg == ONE) begin
          state_next  = TMR_IDLE;
          cnt_next    = '0;
          expire_next = 1'b1;
        end else begin
          cnt_next = cnt_reg - ONE;
        end
      end
      default: begin
        state_next = TMR_IDLE;
        cnt_next   = '0;
      end
    endcase
  end

  // Registers the countdown.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= TMR_IDLE;
      cnt_reg   <= '0;
      o_expire  <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      o_expire  <= expire_next;
    end
  end

  assign o_busy = (state_reg == TMR_COUNT);

endmodule : unblock_timer

//--- dv/smi_host_model.sv
// Host processor model that counts the management interrupts it receives.
`timescale 1ns/1ps
module smi_host_model (
  // Clock and reset.
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // Active-low management interrupt from the device.
  input  wire logic       i_smi_n,
  // Number of interrupt entries seen.
  output logic      [7:0] o_entries
);
  logic smi_q;

  // entry count
  // Each falling edge of the line is one entry; a held line counts only once.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      smi_q     <= 1'b1;
      o_entries <= 8'h00;
    end else begin
      smi_q <= i_smi_n;
      if (smi_q && !i_smi_n) begin
        o_entries <= o_entries + 8'h01;
      end
    end
  end
endmodule : smi_host_model

//--- dv/tb_smi_request_aggregator.sv
// Self-checking testbench of the management-interrupt request aggregator.
`timescale 1ns/1ps
module tb_smi_request_aggregator;
  import smi_agg_pkg::*;
  // Short unblocking window keeps the run brief.
  localparam int UB = 4;

  logic        clk;
  logic        rst_n;
  logic [7:0]  addr;
  logic [15:0] wdata;
  logic        wr_s;
  logic        rd_s;
  logic [15:0] rdata;
  logic [15:0] src_req;
  logic [15:0] irq_line;
  logic        smi_n;
  logic        reload;
  logic        blocked;
  logic        irq;
  logic [7:0]  entries;
  logic [15:0] reload_cnt;
  logic [15:0] r;
  logic [15:0] b;
  logic [15:0] c0;
  int          num_errors;
  int          comparisons;
  int          i;
  int          k;
  int          n_smi;

  smi_request_aggregator #(.UNBLOCK_CNT(UB)) uut (
    .i_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s),
    .i_rd(rd_s), .o_rdata(rdata), .i_src_req(src_req), .i_irq_line(irq_line),
    .o_system_mgmt_interrupt_out_n(smi_n), .o_throttle_reload(reload),
    .o_blocked(blocked), .o_irq(irq)
  );

  smi_host_model host (.i_clk(clk), .i_rst_n(rst_n), .i_smi_n(smi_n), .o_entries(entries));

  // Clock at 200 MHz.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Counts reload pulses from the throttling output.
  always @(posedge clk) begin
    if (!rst_n) reload_cnt <= 16'h0000;
    else if (reload === 1'b1) reload_cnt <= reload_cnt + 16'h0001;
  end

  // ---------------------------------------------------------------------------
  // Tasks and expectation functions
  // ---------------------------------------------------------------------------
  function automatic logic [15:0] exp_sel(input logic [15:0] v);
    return v & SEL_WRITABLE;
  endfunction : exp_sel

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s  <= 1'b0;
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [15:0] exp, input string name);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    chk(name, exp, rdata);
  endtask : rchk

  task automatic pulse(input logic [15:0] v);
    @(posedge clk);
    src_req <= v;
    @(posedge clk);
    src_req <= 16'h0000;
  endtask : pulse

  // Starts the unblocking timer and waits, bounded, for the mask to drop.
  task automatic unblock();
    int n;
    wr(OFS_TRIGGER, 16'h0002);
    for (n = 0; n < UB + 8 && blocked !== 1'b0; n++) begin
      @(posedge clk);
      #1;
    end
    chk("blocked", 16'h0000, 16'(blocked));
  endtask : unblock

  // Waits two edges after a request and expects the line asserted.
  task automatic expect_smi();
    repeat (2) @(posedge clk);
    #1;
    chk("interrupt low", 16'h0000, 16'(smi_n));
    chk("blocked set", 16'h0001, 16'(blocked));
    n_smi++;
  endtask : expect_smi

  task automatic stop_test();
    $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test

  // Watchdog cuts a hung run short.
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    stop_test();
  end

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    void'($urandom(32'hC93E590C));
    rst_n    = 1'b0;
    addr     = 8'h00;
    wdata    = 16'h0000;
    wr_s     = 1'b0;
    rd_s     = 1'b0;
    src_req  = 16'h0000;
    irq_line = 16'h0000;
    n_smi    = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    // Reset values of every register, and the idle line.
    for (i = 0; i < 4; i++) rchk(OFS_REQ_STATUS + 8'(2 * i), 16'h0000, "reset value");
    rchk(OFS_EVT_STATUS, 16'h0000, "event reset");
    rchk(OFS_EVT_MASK, 16'h0000, "mask reset");
    chk("idle line", 16'h0001, 16'(smi_n));
    // Random register contents, reserved select bit, unmapped place.
    for (i = 0; i < 8; i++) begin
      r = 16'($urandom);
      wr(OFS_SRC_SELECT, r);
      rchk(OFS_SRC_SELECT, exp_sel(r), "source select");
      wr(OFS_LINE_SELECT, ~r);
      rchk(OFS_LINE_SELECT, ~r, "line select");
      wr(OFS_RELOAD_SEL, r);
      rchk(OFS_RELOAD_SEL, r, "reload select");
    end
    wr(8'h50, 16'hFFFF);
    rchk(8'h50, 16'h0000, "unmapped read");
    rchk(OFS_TRIGGER, 16'h0000, "trigger read");
    // Unselected sources are not latched.
    wr(OFS_SRC_SELECT, 16'h0000);
    pulse(HW_SRC_MASK & 16'h7FFF);
    rchk(OFS_REQ_STATUS, 16'h0000, "unselected");
    chk("no interrupt", 16'h0001, 16'(smi_n));
    // Every hardware source at its own bit, with write-one-to-clear.
    for (i = 0; i < 16; i++) begin
      if (HW_SRC_MASK[i]) begin
        b = 16'h0001 << i;
        wr(OFS_SRC_SELECT, b);
        pulse(b);
        expect_smi();
        rchk(OFS_REQ_STATUS, b, "status bit");
        wr(OFS_REQ_STATUS, ~b);
        rchk(OFS_REQ_STATUS, b, "zero write");
        wr(OFS_REQ_STATUS, b);
        rchk(OFS_REQ_STATUS, 16'h0000, "one write");
        chk("released", 16'h0001, 16'(smi_n));
        unblock();
      end
    end
    // Event status, mask and the level interrupt.
    wr(OFS_EVT_MASK, 16'h0001);
    rchk(OFS_EVT_STATUS, 16'h0003, "events");
    chk("irq on", 16'h0001, 16'(irq));
    wr(OFS_EVT_STATUS, 16'h0001);
    rchk(OFS_EVT_STATUS, 16'h0002, "event clear");
    chk("irq masked", 16'h0000, 16'(irq));
    wr(OFS_EVT_MASK, 16'h0003);
    rchk(OFS_EVT_MASK, 16'h0003, "mask");
    chk("irq second", 16'h0001, 16'(irq));
    wr(OFS_EVT_STATUS, 16'h0003);
    rchk(OFS_EVT_STATUS, 16'h0000, "events cleared");
    chk("irq off", 16'h0000, 16'(irq));
    // Software trigger: zero does nothing, one asserts at bit 4.
    wr(OFS_SRC_SELECT, 16'h0000);
    wr(OFS_TRIGGER, 16'h0000);
    rchk(OFS_REQ_STATUS, 16'h0000, "trigger zero");
    wr(OFS_TRIGGER, 16'h0001);
    expect_smi();
    rchk(OFS_REQ_STATUS, 16'h0010, "software bit");
    wr(OFS_REQ_STATUS, 16'h0010);
    unblock();
    // A request during the blocking window waits for the timer.
    wr(OFS_SRC_SELECT, 16'h0280);
    pulse(16'h0080);
    expect_smi();
    wr(OFS_REQ_STATUS, 16'h0080);
    pulse(16'h0200);
    repeat (4) @(posedge clk);
    #1;
    chk("held off", 16'h0001, 16'(smi_n));
    rchk(OFS_REQ_STATUS, 16'h0200, "latched blocked");
    wr(OFS_TRIGGER, 16'h0002);
    for (i = 0; i < UB + 8 && smi_n !== 1'b0; i++) @(posedge clk);
    #1;
    chk("after unblock", 16'h0000, 16'(smi_n));
    n_smi++;
    wr(OFS_REQ_STATUS, 16'h0200);
    unblock();
    // Interrupt lines: a disabled line first, then an enabled one.
    k = $urandom_range(15, 0);
    wr(OFS_SRC_SELECT, 16'h2000);
    wr(OFS_LINE_SELECT, 16'h0001 << k);
    wr(OFS_RELOAD_SEL, 16'h0001 << k);
    c0 = reload_cnt;
    @(posedge clk);
    irq_line <= 16'h0001 << (k ^ 1);
    repeat (8) @(posedge clk);
    rchk(OFS_REQ_STATUS, 16'h0000, "line disabled");
    chk("no reload", c0, reload_cnt);
    irq_line <= (16'h0001 << (k ^ 1)) | (16'h0001 << k);
    repeat (8) @(posedge clk);
    rchk(OFS_REQ_STATUS, 16'h2000, "line request");
    chk("reload pulse", c0 + 16'h0001, reload_cnt);
    n_smi++;
    irq_line <= 16'h0000;
    wr(OFS_REQ_STATUS, 16'h2000);
    unblock();
    chk("host entries", 16'(n_smi), {8'h00, entries});
    // A reset in mid-run returns the status and three select registers and the line to idle.
    wr(OFS_SRC_SELECT, 16'h7FFF);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 4; i++) rchk(OFS_REQ_STATUS + 8'(2 * i), 16'h0000, "reset again");
    chk("reset line", 16'h0001, 16'(smi_n));
    chk("reset blocked", 16'h0000, 16'(blocked));
    stop_test();
  end
endmodule : tb_smi_request_aggregator
